//--- logic/licr_pkg.sv
/*
 * Constants for the line interface control register block: register offsets,
 * field positions, reset values, field encodings and on-hook release timing.
 * Assumes a single 250 MHz clock and an Avalon-MM register slave with 32-bit data.
 */
package licr_pkg;
	localparam logic [7:0] OFS_LINE_CTRL   = 8'h10;
	localparam logic [7:0] OFS_LIMIT_CTRL  = 8'h11;
	localparam logic [7:0] OFS_LINE_STATUS = 8'h12;

	localparam int BIT_TERM_OFF_SQL = 7;
	localparam int BIT_ONHOOK_SPEED = 6;
	localparam int BIT_AC_TERM      = 5;
	localparam int BIT_RESERVED     = 4;
	localparam int BIT_DC_MODE_HI   = 3;
	localparam int BIT_DC_MODE_LO   = 2;
	localparam int BIT_RINGER_Z     = 1;
	localparam int BIT_RING_THRESH  = 0;
	localparam int BIT_CUR_LIMIT    = 0;

	localparam logic [7:0] LINE_CTRL_RESET  = 8'h00;
	localparam logic [7:0] LINE_CTRL_WMASK  = 8'hef;

	typedef enum logic [1:0] {
		LICR_DC_LOW_V    = 2'b00,
		LICR_DC_LOWER_V  = 2'b01,
		LICR_DC_STD_V    = 2'b10,
		LICR_DC_CUR_LIM  = 2'b11
	} licr_dc_mode_t;

	typedef enum logic [1:0] {
		LICR_HK_ON       = 2'b00,
		LICR_HK_OFF      = 2'b01,
		LICR_HK_RELEASE  = 2'b10
	} licr_hook_t;

	localparam int FAST_ONHOOK_SAMPLES = 1024;
	localparam int SLOW_ONHOOK_SAMPLES = 4096;
	localparam int SAMPLE_CNT_W        = 13;
endpackage

//--- logic/licr_onhook_timer.sv
/*
 * Counts sample strobes for the on-hook release interval.
 * Assumes sample_tick is a one-cycle pulse once per sample period.
 */
`timescale 1ns/10ps
module licr_onhook_timer #(
	parameter int CNT_W = licr_pkg::SAMPLE_CNT_W
) (
	input  wire logic             clock,       // System clock.
	input  wire logic             arst_n,      // Asynchronous reset, active low.
	input  wire logic             start,       // Begin a release interval.
	input  wire logic             sample_tick, // One pulse per sample period.
	input  wire logic [CNT_W-1:0] length,      // Samples in the interval.
	output logic                  done         // Pulse when interval ends.
);
	logic [CNT_W-1:0] count_reg;
	logic             run_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
			run_reg   <= 1'b0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_reg <= length;
				run_reg   <= 1'b1;
			end else if (run_reg && sample_tick) begin
				if (count_reg <= CNT_W'(1)) begin
					run_reg <= 1'b0;
					done    <= 1'b1;
				end
				count_reg <= count_reg - CNT_W'(1);
			end
		end
	end
endmodule

//--- logic/licr_line_ctrl.sv
/*
 * Line interface control register with its decoded line controls.
 * Assumes an Avalon-MM master with 32-bit data, a sample strobe at the
 * sample rate and a hook request level from the rest of the device.
 */
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module licr_line_ctrl (
	input  wire logic        clock,              // 250 MHz system clock.
	input  wire logic        arst_n,             // Asynchronous reset, active low.
	input  wire logic [7:0]  avs_address,        // Byte address.
	input  wire logic        avs_read,           // Read request.
	input  wire logic        avs_write,          // Write request.
	input  wire logic [31:0] avs_writedata,      // Write data.
	input  wire logic [3:0]  avs_byteenable,     // Byte enables.
	output logic [31:0]      avs_readdata,       // Read data.
	output logic             avs_waitrequest,    // Stall until answer is ready.
	output logic [1:0]       avs_response,       // 00 okay, 10 slave error.
	input  wire logic        offhook_req,        // Host asks to be off-hook.
	input  wire logic        sample_tick,        // One pulse per sample period.
	output logic             offhook,            // Line is seized.
	output logic             dc_term_off,        // DC termination disabled, 800 ohm.
	output logic             term_pin_reduce,    // Lower termination pin voltage.
	output logic             ring_squelch,       // Ring network squelch active.
	output logic             ac_term_complex,    // Complex AC impedance selected.
	output logic [1:0]       dc_term_mode,       // DC termination mode.
	output logic [1:0]       tx_level_sel,       // 0:-5, 1:-3, 2:-1 dBm.
	output logic             current_limit_on,   // Limit below 60 mA.
	output logic             ringer_synth,       // Synthesized ringer impedance.
	output logic             ring_thresh_high    // 17 to 33 Vrms window.
);
	logic [7:0]       ctrl_reg;
	logic             limit_reg;
	logic             ack_reg;
	licr_pkg::licr_hook_t hook_reg;
	logic             rel_done;
	logic             rel_start;
	logic [licr_pkg::SAMPLE_CNT_W-1:0] rel_len;
	logic             req;
	logic             hit_ctrl;
	logic             hit_lim;
	logic             hit_stat;

	assign req      = (avs_read || avs_write) && !ack_reg;
	assign hit_ctrl = avs_address == licr_pkg::OFS_LINE_CTRL;
	assign hit_lim  = avs_address == licr_pkg::OFS_LIMIT_CTRL;
	assign hit_stat = avs_address == licr_pkg::OFS_LINE_STATUS;
	assign rel_start = hook_reg == licr_pkg::LICR_HK_OFF && !offhook_req;
	// Speed bit chooses the release counter length.
	assign rel_len = ctrl_reg[licr_pkg::BIT_ONHOOK_SPEED]
		? licr_pkg::SAMPLE_CNT_W'(licr_pkg::SLOW_ONHOOK_SAMPLES)
		: licr_pkg::SAMPLE_CNT_W'(licr_pkg::FAST_ONHOOK_SAMPLES);

	// One wait cycle, then acknowledge; waitrequest rises again after each answer.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ack_reg         <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_reg         <= req;
			avs_waitrequest <= !req;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg  <= licr_pkg::LINE_CTRL_RESET;
			limit_reg <= 1'b0;
		// A write lands only at the edge where the master sees waitrequest low.
		end else if (!avs_waitrequest && avs_write && avs_byteenable[0]) begin
			if (hit_ctrl) begin
				ctrl_reg <= avs_writedata[7:0] & licr_pkg::LINE_CTRL_WMASK;
			end
			if (hit_lim) begin
				limit_reg <= avs_writedata[licr_pkg::BIT_CUR_LIMIT];
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= '0;
			avs_response <= 2'b00;
		end else if (req) begin
			avs_readdata <= '0;
			avs_response <= (hit_ctrl || hit_lim || hit_stat) ? 2'b00 : 2'b10;
			if (avs_read && hit_ctrl) begin
				avs_readdata[7:0] <= ctrl_reg;
			end
			if (avs_read && hit_lim) begin
				avs_readdata[licr_pkg::BIT_CUR_LIMIT] <= limit_reg;
			end
			if (avs_read && hit_stat) begin
				avs_readdata[0] <= offhook;
			end
		end
	end

	// Hook state: the line stays seized through the release interval.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hook_reg <= licr_pkg::LICR_HK_ON;
		end else begin
			unique case (hook_reg)
				licr_pkg::LICR_HK_ON: begin
					if (offhook_req) hook_reg <= licr_pkg::LICR_HK_OFF;
				end
				licr_pkg::LICR_HK_OFF: begin
					if (!offhook_req) hook_reg <= licr_pkg::LICR_HK_RELEASE;
				end
				licr_pkg::LICR_HK_RELEASE: begin
					if (offhook_req) hook_reg <= licr_pkg::LICR_HK_OFF;
					else if (rel_done) hook_reg <= licr_pkg::LICR_HK_ON;
				end
				default: hook_reg <= licr_pkg::LICR_HK_ON;
			endcase
		end
	end

	licr_onhook_timer #(.CNT_W(licr_pkg::SAMPLE_CNT_W)) licr_onhook_timer_inst (
		.clock       (clock),
		.arst_n      (arst_n),
		.start       (rel_start),
		.sample_tick (sample_tick),
		.length      (rel_len),
		.done        (rel_done)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			offhook          <= 1'b0;
			dc_term_off      <= 1'b0;
			term_pin_reduce  <= 1'b0;
			ring_squelch     <= 1'b0;
			ac_term_complex  <= 1'b0;
			dc_term_mode     <= licr_pkg::LICR_DC_LOW_V;
			tx_level_sel     <= 2'b00;
			current_limit_on <= 1'b0;
			ringer_synth     <= 1'b0;
			ring_thresh_high <= 1'b0;
		end else begin
			offhook          <= hook_reg != licr_pkg::LICR_HK_ON;
			// The shared top bit is steered by the hook state.
			dc_term_off      <= hook_reg != licr_pkg::LICR_HK_ON && ctrl_reg[licr_pkg::BIT_TERM_OFF_SQL];
			term_pin_reduce  <= hook_reg != licr_pkg::LICR_HK_ON && ctrl_reg[licr_pkg::BIT_TERM_OFF_SQL];
			ring_squelch     <= hook_reg == licr_pkg::LICR_HK_ON && ctrl_reg[licr_pkg::BIT_TERM_OFF_SQL];
			ac_term_complex  <= ctrl_reg[licr_pkg::BIT_AC_TERM];
			dc_term_mode     <= ctrl_reg[licr_pkg::BIT_DC_MODE_HI:licr_pkg::BIT_DC_MODE_LO];
			unique case (licr_pkg::licr_dc_mode_t'(ctrl_reg[licr_pkg::BIT_DC_MODE_HI:licr_pkg::BIT_DC_MODE_LO]))
				licr_pkg::LICR_DC_LOW_V:   tx_level_sel <= 2'b00;
				licr_pkg::LICR_DC_LOWER_V: tx_level_sel <= 2'b01;
				licr_pkg::LICR_DC_STD_V:   tx_level_sel <= 2'b10;
				licr_pkg::LICR_DC_CUR_LIM: tx_level_sel <= 2'b10;
			endcase
			current_limit_on <= limit_reg && ctrl_reg[licr_pkg::BIT_DC_MODE_HI:licr_pkg::BIT_DC_MODE_LO]
				== licr_pkg::LICR_DC_CUR_LIM;
			ringer_synth     <= ctrl_reg[licr_pkg::BIT_RINGER_Z];
			ring_thresh_high <= ctrl_reg[licr_pkg::BIT_RING_THRESH];
		end
	end
endmodule

//--- sim/licr_line_ctrl_properties.sv
/* Checker for the line control register block: bus answer timing and decoded line controls.
   Assumes it is bound to licr_line_ctrl and sees only its ports. */
`timescale 1ns/10ps
module licr_line_ctrl_checker (
	input wire logic        clock,           // Clock.
	input wire logic        arst_n,          // Reset.
	input wire logic        avs_read,        // Read.
	input wire logic        avs_write,       // Write.
	input wire logic [31:0] avs_readdata,    // Read data.
	input wire logic        avs_waitrequest, // Stall.
	input wire logic        offhook,         // Seized.
	input wire logic        dc_term_off,     // Term off.
	input wire logic        term_pin_reduce, // Pin low.
	input wire logic        ring_squelch,    // Squelch.
	input wire logic [1:0]  dc_term_mode,    // DC mode.
	input wire logic [1:0]  tx_level_sel,    // Level.
	input wire logic        current_limit_on // Limit.
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
	property p_ans; s_req |=> s_ans; endproperty
	property p_upper; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
	property p_off; dc_term_off |-> offhook; endproperty
	property p_sql; ring_squelch |-> !offhook; endproperty
	property p_excl; !(dc_term_off && ring_squelch); endproperty
	property p_pin; term_pin_reduce == dc_term_off; endproperty
	property p_tx; tx_level_sel == (dc_term_mode[1] ? 2'b10 : dc_term_mode); endproperty
	property p_lim; current_limit_on |-> dc_term_mode == 2'b11; endproperty
	a_ans: assert property (p_ans) else $error("bus answer not a one-cycle stall drop");
	a_upper: assert property (p_upper) else $error("upper read data not zero");
	a_off: assert property (p_off) else $error("termination off while on-hook");
	a_sql: assert property (p_sql) else $error("squelch while off-hook");
	a_excl: assert property (p_excl) else $error("top bit drives both meanings");
	a_pin: assert property (p_pin) else $error("pin reduce differs from termination off");
	a_tx: assert property (p_tx) else $error("transmit level wrong for mode");
	a_lim: assert property (p_lim) else $error("current limit outside limiting mode");
endmodule
bind licr_line_ctrl licr_line_ctrl_checker licr_line_ctrl_checker_inst (.clock, .arst_n, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .offhook, .dc_term_off, .term_pin_reduce,
	.ring_squelch, .dc_term_mode, .tx_level_sel, .current_limit_on);

//--- sim/test_line_interface_control_register.sv
/* Self-checking bench for the line control register block.
   Assumes the one-cycle Avalon answer; sample ticks run every cycle to keep release counts short. */
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module test_line_interface_control_register;
	logic        clock, arst_n, avs_read, avs_write, offhook_req, sample_tick, avs_waitrequest, offhook;
	logic        dc_term_off, term_pin_reduce, ring_squelch, ac_term_complex, current_limit_on;
	logic        ringer_synth, ring_thresh_high;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	logic [3:0]  avs_byteenable;
	logic [1:0]  avs_response, resp, dc_term_mode, tx_level_sel;
	int          miscompares, checks, n;
	licr_line_ctrl licr_line_ctrl_inst (.clock, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .offhook_req, .sample_tick, .offhook,
		.dc_term_off, .term_pin_reduce, .ring_squelch, .ac_term_complex, .dc_term_mode, .tx_level_sel,
		.current_limit_on, .ringer_synth, .ring_thresh_high);
	task test_done;
		$display("miscompares %0d checks %0d", miscompares, checks);
		if (miscompares == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin @(posedge clock); k++; end while (avs_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin miscompares++; test_done(); end
		rdata = avs_readdata;
		resp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rdata, e)
	endtask
	task settle;
		repeat (3) @(posedge clock);
	endtask
	// Seize with the top bit set, then time the release in sample ticks.
	task hook(input logic [31:0] ctl, input int len);
		xfer(1'b1, 8'h10, ctl);
		offhook_req <= 1'b1;
		settle();
		`CHK({offhook, dc_term_off, term_pin_reduce, ring_squelch}, 4'b1110)
		rd(8'h12, 32'h1);
		offhook_req <= 1'b0;
		n = 0;
		do begin @(posedge clock); n++; end while (offhook !== 1'b0 && n < 6000);
		`CHK(n >= len && n <= len + 6, 1'b1)
		settle();
		`CHK({dc_term_off, ring_squelch}, 2'b01)
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		#200000;
		miscompares++;
		test_done();
	end
	initial begin
		{arst_n, avs_read, avs_write, offhook_req, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		sample_tick = 1'b1;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		rd(8'h10, 32'h0);
		xfer(1'b1, 8'h10, 32'hff);
		rd(8'h10, 32'hef);
		settle();
		`CHK({ac_term_complex, ringer_synth, ring_thresh_high, ring_squelch, dc_term_off}, 5'b11110)
		xfer(1'b1, 8'h11, 32'h1);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, 8'h10, 32'(m) << 2);
			settle();
			`CHK(dc_term_mode, 2'(m))
			`CHK(tx_level_sel, (m > 1) ? 2'b10 : 2'(m))
			`CHK(current_limit_on, m == 3)
			`CHK({ac_term_complex, ringer_synth, ring_thresh_high}, 3'b000)
		end
		rd(8'h20, 32'h0);
		`CHK(resp, 2'b10)
		hook(32'h80, 1024);
		hook(32'hc0, 4096);
		rd(8'h12, 32'h0);
		// Lane 0 disabled: the write must be dropped.
		avs_byteenable <= 4'he;
		xfer(1'b1, 8'h10, 32'h0);
		avs_byteenable <= 4'hf;
		rd(8'h10, 32'hc0);
		// Software clears the squelch bit before the next ring.
		xfer(1'b1, 8'h10, 32'h40);
		settle();
		`CHK(ring_squelch, 1'b0)
		// Limit bit cleared: limiting mode alone must not limit.
		xfer(1'b1, 8'h11, 32'h0);
		xfer(1'b1, 8'h10, 32'h0c);
		settle();
		`CHK(current_limit_on, 1'b0)
		rd(8'h11, 32'h0);
		test_done();
	end
endmodule
